// >>> sebc_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes an axi4-lite slave with 32-bit data, byte addresses
`ifndef SEBC_REGS_SVH
`define SEBC_REGS_SVH
`define SEBC_OFS_BUS_CONFIG 8'h00
`define SEBC_OFS_ERR_STATUS 8'h04
`define SEBC_OFS_ERR_DISABLE 8'h08
`define SEBC_OFS_ERR_ATTR 8'h0c
`define SEBC_OFS_ERR_ADDR 8'h10
`define SEBC_OFS_IRQ_ENABLE 8'h14
`define SEBC_OFS_IRQ_CLEAR 8'h18
`define SEBC_OFS_BANK_BASE 8'h1c
`define SEBC_OFS_STATUS 8'h20
`define SEBC_BMT_LSB 8
`define SEBC_BMT_MSB 15
`define SEBC_MONITOR_PRESCALE_LSB 0
`define SEBC_MONITOR_PRESCALE_MSB 3
`define SEBC_BUS_CONFIG_RST 32'h0000_0000
`define SEBC_BANK_BASE_RST 32'h0000_0000
`define SEBC_BANK_RSVD_BIT 30
`define SEBC_ERR_BM 0
`define SEBC_ERR_PAR 1
`define SEBC_SOURCE_IDENTIFIER_LSB 11
`define SEBC_SOURCE_IDENTIFIER_MSB 15
`define SEBC_ATTR_WRITE_BIT 0
`define SEBC_ATTR_FLASH_BIT 1
`define SEBC_BMT_ZERO_COUNT 9'h100
`define SEBC_ALE_IGNORE_CYCLES 4'h8
`endif

// >>> sebc_pkg.sv
// types shared by the bus controller files
// assumes nothing beyond a systemverilog compiler
package sebc_pkg;
    typedef enum logic [1:0] {
        SEBC_M_FLASH = 2'b00,
        SEBC_M_GP = 2'b01,
        SEBC_M_PROG = 2'b10
    } sebc_machine_t;
    typedef enum logic [1:0] {
        SEBC_IDLE = 2'b00,
        SEBC_BUSY = 2'b01,
        SEBC_DONE = 2'b10
    } sebc_state_t;
endpackage

// >>> sebc_wait_sync.sv
// programmable wait input synchroniser
// assumes the wait input is steady around falling clock edges
module sebc_wait_sync (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic programmable_wait_in,
    output logic wait_sync_out
);
    logic wait_fall;
    // first stage on the falling edge, second on the rising
    always_ff @(negedge clock_in) begin
        if (!rst_n_in) begin
            wait_fall <= 1'b0;
        end else begin
            wait_fall <= programmable_wait_in;
        end
    end
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            wait_sync_out <= 1'b0;
        end else begin
            wait_sync_out <= wait_fall;
        end
    end
endmodule

// >>> sebc_top.sv
// shared external bus controller: queue, bus monitor, error capture, regs
// assumes an axi4-lite master and one request port from the internal side
//
// Chosen here: the register offsets and the AXI4-Lite slave port.
`include "sebc_regs.svh"
//Contract
// - one shared pin set, later requests queued
// - status records only enabled error checks
// - disable bits suppress matching error detection
// - monitor counts bmt times prescale, zero means 256
// - strobe ignored 8 clocks after power reset
// - queued transaction starts monitor while waiting; here only when queued behind a flash special op
// - external logic supplies bank address both phases
// - wait input synchronised from falling edge
// - capture not reliable during flash special op
// - source identifier captured in error attributes
// - parity checked on single accesses only; here on single reads only
// - bank base reserved bit 30 resets zero
// - non-multiplexed mode drives strobe as address 10
module sebc_top (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic power_on_reset_in,
    input wire logic hard_reset_in,
    input wire logic non_mux_mode_in,
    input wire logic rcw_from_bus_in,
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic req_valid_in,
    input wire logic [1:0] req_machine_in,
    input wire logic [31:0] req_addr_in,
    input wire logic req_write_in,
    input wire logic req_single_in,
    input wire logic req_special_in,
    input wire logic [4:0] req_source_in,
    output logic req_ready_out,
    output logic req_done_out,
    output logic req_timeout_out,
    input wire logic ext_ack_in,
    input wire logic parity_error_in,
    input wire logic programmable_wait_in,
    output logic [31:0] local_address_bus_out,
    output logic address_latch_strobe_out,
    output logic bus_active_out,
    output logic irq_out
);
    sebc_pkg::sebc_state_t state;
    logic [31:0] bus_config;
    logic [31:0] bank_base;
    logic [1:0] err_status;
    logic [1:0] err_disable;
    logic [1:0] irq_enable;
    logic [31:0] error_attributes;
    logic [31:0] err_addr;
    logic [31:0] cur_addr;
    logic cur_write;
    logic cur_single;
    logic cur_special;
    logic [4:0] cur_source;
    logic [1:0] cur_machine;
    logic [3:0] flash_left;
    logic [12:0] mon_count;
    logic queued;
    logic [3:0] ale_hold;
    logic wait_sync;
    logic aw_held;
    logic w_held;
    logic [31:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [12:0] next_period;
    logic [8:0] bmt_count;
    logic [4:0] ps_factor;
    logic expire;
    logic finish;
    logic [1:0] ev;
    logic [1:0] clr;
    logic ale_ignore;

    sebc_wait_sync u_wait (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .programmable_wait_in(programmable_wait_in),
        .wait_sync_out(wait_sync)
    );

    // period: bmt times prescale plus one, a zero bmt counts as 256
    always_comb begin
        bmt_count = (bus_config[`SEBC_BMT_MSB:`SEBC_BMT_LSB] == 8'h00) ?
            `SEBC_BMT_ZERO_COUNT : {1'b0, bus_config[`SEBC_BMT_MSB:`SEBC_BMT_LSB]};
        ps_factor = {1'b0, bus_config[`SEBC_MONITOR_PRESCALE_MSB:`SEBC_MONITOR_PRESCALE_LSB]} + 5'h01;
        next_period = 13'(bmt_count) * 13'(ps_factor);
    end

    assign expire = (state == sebc_pkg::SEBC_BUSY) && (mon_count == 13'h0001);
    // programmable machine also waits for the synchronised wait input
    assign finish = (state == sebc_pkg::SEBC_BUSY) && ext_ack_in && flash_left == 4'h0 &&
        !(cur_machine == sebc_pkg::SEBC_M_PROG && wait_sync);
    assign ev[`SEBC_ERR_BM] = expire && !err_disable[`SEBC_ERR_BM];
    assign ev[`SEBC_ERR_PAR] = finish && !cur_write && cur_single && parity_error_in &&
        !err_disable[`SEBC_ERR_PAR];
    assign clr = (aw_held && w_held && !bvalid && aw_addr_q[7:0] == `SEBC_OFS_IRQ_CLEAR) ?
        w_data_q[1:0] : 2'b00;

    // transaction sequencer: one at a time on the shared pins
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            state <= sebc_pkg::SEBC_IDLE;
            req_ready_out <= 1'b0;
            req_done_out <= 1'b0;
            req_timeout_out <= 1'b0;
            bus_active_out <= 1'b0;
            cur_addr <= 32'h0000_0000;
            cur_write <= 1'b0;
            cur_single <= 1'b0;
            cur_special <= 1'b0;
            cur_source <= 5'h00;
            cur_machine <= 2'b00;
            flash_left <= 4'h0;
            queued <= 1'b0;
        end else begin
            req_ready_out <= 1'b0;
            req_done_out <= 1'b0;
            req_timeout_out <= 1'b0;
            case (state)
                sebc_pkg::SEBC_IDLE: begin
                    if (req_valid_in && !req_ready_out) begin
                        req_ready_out <= 1'b1;
                        state <= sebc_pkg::SEBC_BUSY;
                        bus_active_out <= 1'b1;
                        cur_addr <= req_addr_in;
                        cur_write <= req_write_in;
                        cur_single <= req_single_in;
                        cur_special <= req_special_in;
                        cur_source <= req_source_in;
                        cur_machine <= req_machine_in;
                        flash_left <= req_special_in ? 4'hf : 4'h0;
                    end
                end
                sebc_pkg::SEBC_BUSY: begin
                    if (req_valid_in && !req_ready_out) begin
                        queued <= 1'b1;
                    end
                    if (flash_left != 4'h0) begin
                        flash_left <= flash_left - 4'h1;
                    end
                    if (expire) begin
                        req_timeout_out <= 1'b1;
                        state <= sebc_pkg::SEBC_DONE;
                        bus_active_out <= 1'b0;
                    end else if (finish) begin
                        req_done_out <= 1'b1;
                        state <= sebc_pkg::SEBC_DONE;
                        bus_active_out <= 1'b0;
                    end
                end
                sebc_pkg::SEBC_DONE: begin
                    state <= sebc_pkg::SEBC_IDLE;
                    queued <= 1'b0;
                end
                default: begin
                    state <= sebc_pkg::SEBC_IDLE;
                end
            endcase
        end
    end

    // bus monitor, loaded when a request is taken, and again when one is queued behind a flash special op
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            mon_count <= 13'h0000;
        end else if (state == sebc_pkg::SEBC_IDLE && req_valid_in && !req_ready_out) begin
            mon_count <= next_period;
        end else if (state == sebc_pkg::SEBC_BUSY && cur_special && req_valid_in &&
            !req_ready_out && !queued) begin
            mon_count <= next_period;
        end else if (state != sebc_pkg::SEBC_BUSY || finish) begin
            mon_count <= 13'h0000;
        end else if (mon_count != 13'h0000) begin
            mon_count <= mon_count - 13'h0001;
        end
    end

    // error status: set wins over clear
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            err_status <= 2'b00;
        end else begin
            err_status <= (err_status & ~clr) | ev;
        end
    end

    // capture; skipped for the whole of a transaction that is a flash special op
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            error_attributes <= 32'h0000_0000;
            err_addr <= 32'h0000_0000;
        end else if (ev != 2'b00 && !cur_special) begin
            err_addr <= cur_addr;
            error_attributes <= 32'h0000_0000;
            error_attributes[`SEBC_SOURCE_IDENTIFIER_MSB:`SEBC_SOURCE_IDENTIFIER_LSB] <= cur_source;
            error_attributes[`SEBC_ATTR_WRITE_BIT] <= cur_write;
            error_attributes[`SEBC_ATTR_FLASH_BIT] <= cur_machine == sebc_pkg::SEBC_M_FLASH;
        end
    end

    // strobe / address pins
    assign ale_ignore = rcw_from_bus_in ? (ale_hold != 4'h0) : hard_reset_in;
    always_ff @(posedge clock_in) begin
        if (!rst_n_in || power_on_reset_in) begin
            ale_hold <= `SEBC_ALE_IGNORE_CYCLES;
        end else if (ale_hold != 4'h0) begin
            ale_hold <= ale_hold - 4'h1;
        end
    end
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            address_latch_strobe_out <= 1'b0;
            local_address_bus_out <= 32'h0000_0000;
        end else begin
            local_address_bus_out <= cur_addr;
            if (non_mux_mode_in) begin
                address_latch_strobe_out <= cur_addr[10];
            end else begin
                // strobe held low while the reset word may still be fetched
                address_latch_strobe_out <= !ale_ignore && req_ready_out;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(((err_status & ~clr) | ev) & irq_enable);
        end
    end

    // axi4-lite write side
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr_q <= 32'h0000_0000;
            w_data_q <= 32'h0000_0000;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= 2'b00;
            bus_config <= `SEBC_BUS_CONFIG_RST;
            bank_base <= `SEBC_BANK_BASE_RST;
            err_disable <= 2'b00;
            irq_enable <= 2'b00;
        end else begin
            awready <= !aw_held && awvalid && !awready;
            wready <= !w_held && wvalid && !wready;
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                w_data_q <= wdata;
            end
            if (aw_held && w_held && !bvalid) begin
                bvalid <= 1'b1;
                bresp <= 2'b00;
                case (aw_addr_q[7:0])
                    `SEBC_OFS_BUS_CONFIG: bus_config <= w_data_q;
                    `SEBC_OFS_ERR_DISABLE: err_disable <= w_data_q[1:0];
                    `SEBC_OFS_ERR_ATTR: begin
                    end
                    `SEBC_OFS_IRQ_ENABLE: irq_enable <= w_data_q[1:0];
                    `SEBC_OFS_IRQ_CLEAR: begin
                    end
                    `SEBC_OFS_BANK_BASE: begin
                        bank_base <= w_data_q;
                        bank_base[`SEBC_BANK_RSVD_BIT] <= 1'b0;
                    end
                    default: bresp <= 2'b10;
                endcase
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                aw_held <= 1'b0;
                w_held <= 1'b0;
            end
        end
    end

    // axi4-lite read side
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= 2'b00;
        end else begin
            arready <= arvalid && !arready && !rvalid;
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rresp <= 2'b00;
                case (araddr[7:0])
                    `SEBC_OFS_BUS_CONFIG: rdata <= bus_config;
                    `SEBC_OFS_ERR_STATUS: rdata <= {30'h0, err_status};
                    `SEBC_OFS_ERR_DISABLE: rdata <= {30'h0, err_disable};
                    `SEBC_OFS_ERR_ATTR: rdata <= error_attributes;
                    `SEBC_OFS_ERR_ADDR: rdata <= err_addr;
                    `SEBC_OFS_IRQ_ENABLE: rdata <= {30'h0, irq_enable};
                    `SEBC_OFS_BANK_BASE: rdata <= bank_base;
                    `SEBC_OFS_STATUS: rdata <= {28'h0, flash_left == 4'h0, wait_sync,
                        state};
                    default: begin
                        rdata <= 32'h0000_0000;
                        rresp <= 2'b10;
                    end
                endcase
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end
endmodule

// >>> sebc_top_assertions.sv
// port checker for the shared external bus controller
// assumes one clock domain and a synchronous active-low reset
module sebc_top_checker (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic power_on_reset_in,
    input wire logic hard_reset_in,
    input wire logic rcw_from_bus_in,
    input wire logic non_mux_mode_in,
    input wire logic bready,
    input wire logic bvalid,
    input wire logic rready,
    input wire logic rvalid,
    input wire logic [31:0] rdata,
    input wire logic req_ready_out,
    input wire logic req_done_out,
    input wire logic req_timeout_out,
    input wire logic address_latch_strobe_out,
    input wire logic bus_active_out,
    input wire logic irq_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_n_in);
    property p_take;
        req_ready_out |-> bus_active_out && !$past(bus_active_out);
    endproperty
    a_take: assert property (p_take) else $error("take while pins busy");
    property p_gap;
        req_done_out || req_timeout_out |=> !req_ready_out;
    endproperty
    a_gap: assert property (p_gap) else $error("take right after finish");
    property p_done;
        req_done_out |-> !bus_active_out && !req_timeout_out;
    endproperty
    a_done: assert property (p_done) else $error("bad normal finish");
    property p_tmo;
        req_timeout_out |-> $past(bus_active_out) && !bus_active_out;
    endproperty
    a_tmo: assert property (p_tmo) else $error("bad expiry finish");
    property p_por;
        $fell(power_on_reset_in) && rcw_from_bus_in && !non_mux_mode_in |=>
            !address_latch_strobe_out [*7];
    endproperty
    a_por: assert property (p_por) else $error("strobe early after power reset");
    property p_hrst;
        hard_reset_in && !rcw_from_bus_in && !non_mux_mode_in |=> !address_latch_strobe_out;
    endproperty
    a_hrst: assert property (p_hrst) else $error("strobe during hard reset");
    property p_bhold;
        bvalid && !bready |=> bvalid;
    endproperty
    a_bhold: assert property (p_bhold) else $error("write answer dropped");
    property p_rhold;
        rvalid && !rready |=> rvalid && $stable(rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read answer dropped");
    c_done: cover property (req_done_out);
    c_tmo: cover property (req_timeout_out);
    c_irq: cover property ($rose(irq_out));
endmodule
bind sebc_top sebc_top_checker chk (.*);

// >>> sebc_ext_model.sv
// external memory device on the shared pins
// assumes the bench sets answer delay, wait length and parity fault
module sebc_ext_model (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic bus_active_in,
    input wire logic [7:0] ack_delay_in,
    input wire logic [7:0] wait_len_in,
    input wire logic par_fault_in,
    output logic ext_ack_out,
    output logic parity_error_out,
    output logic wait_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] age;
    // strobe ignored, address taken by plain latch
    // bank address held by the device through both phases
    always_ff @(posedge clock_in) begin
        if (!rst_n_in || !bus_active_in)
            age <= 8'h00;
        else if (age != 8'hff)
            age <= age + 8'h01;
    end
    // delay ff is a device that never answers
    assign ext_ack_out = bus_active_in && ack_delay_in != 8'hff && age >= ack_delay_in;
    assign wait_out = bus_active_in && age < wait_len_in;
    assign parity_error_out = par_fault_in && ext_ack_out;
endmodule

// >>> test_shared_external_bus_controller.sv
// self-checking bench for the shared external bus controller
// assumes the top, its checker bind and the device model
module test_shared_external_bus_controller;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock_in, rst_n_in, power_on_reset_in, hard_reset_in, non_mux_mode_in;
    logic rcw_from_bus_in, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, req_valid_in, req_write_in, req_single_in;
    logic req_special_in, req_ready_out, req_done_out, req_timeout_out, ext_ack_in;
    logic parity_error_in, programmable_wait_in, address_latch_strobe_out;
    logic bus_active_out, irq_out, par_fault, dn, tm;
    logic [1:0] bresp, rresp, req_machine_in, rs, ws;
    logic [3:0] wstrb;
    logic [4:0] req_source_in;
    logic [7:0] ack_dly, wait_len;
    logic [31:0] awaddr, wdata, araddr, rdata, req_addr_in, local_address_bus_out, rv;
    int errors, compares, n;
    sebc_top dut (.*);
    sebc_ext_model ext (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .bus_active_in(bus_active_out), .ack_delay_in(ack_dly), .wait_len_in(wait_len),
        .par_fault_in(par_fault), .ext_ack_out(ext_ack_in),
        .parity_error_out(parity_error_in), .wait_out(programmable_wait_in));
    initial begin
        clock_in = 1'b0;
        forever #12.5 clock_in = ~clock_in;
    end
    task automatic final_report;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic hang;
        errors++;
        final_report;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            errors++;
            $display("Error %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clock_in);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clock_in);
        awaddr <= {24'h000000, a};
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        for (k = 0; k < 50; k++) begin
            @(posedge clock_in);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        ws = bresp;
        bready <= 1'b0;
        if (k == 50) hang;
    endtask
    task automatic rd(input logic [7:0] a);
        int k;
        @(posedge clock_in);
        araddr <= {24'h000000, a};
        {arvalid, rready} <= 2'h3;
        for (k = 0; k < 50; k++) begin
            @(posedge clock_in);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        {rs, rv} = {rresp, rdata};
        rready <= 1'b0;
        if (k == 50) hang;
    endtask
    task automatic tx(input logic [1:0] m, input logic [31:0] a, input logic w, s, sp);
        @(posedge clock_in);
        {req_machine_in, req_addr_in, req_source_in} <= {m, a, 5'h13};
        {req_write_in, req_single_in, req_special_in, req_valid_in} <= {w, s, sp, 1'b1};
        n = 0;
        do begin
            @(posedge clock_in);
            n++;
        end while (!req_ready_out && n < 5000);
        req_valid_in <= 1'b0;
        if (n < 5000) n = 0;
        do begin
            @(posedge clock_in);
            n++;
        end while (!req_done_out && !req_timeout_out && n < 5000);
        {dn, tm} = {req_done_out, req_timeout_out};
        if (n >= 5000) hang;
    endtask
    task automatic t_regs;
        rd(8'h00);
        chk(rv, 32'h0);
        rd(8'h1c);
        chk(rv, 32'h0);
        wr(8'h1c, 32'hffff_ffff);
        chk(ws, 2'h0);
        wr(8'h20, 32'h0);
        chk(ws, 2'h2);
        rd(8'h1c);
        chk(rv, 32'hbfff_ffff);
        rd(8'h40);
        chk(rs, 2'h2);
        rd(8'h18);
        chk(rs, 2'h2);
    endtask
    task automatic t_done;
        ack_dly <= 8'h03;
        tx(2'h0, 32'h0000_0100, 1'b0, 1'b1, 1'b0);
        chk({dn, tm}, 2'h2);
        tx(2'h1, 32'h0000_0104, 1'b1, 1'b0, 1'b0);
        chk({dn, tm}, 2'h2);
        tx(2'h0, 32'h0000_0108, 1'b1, 1'b0, 1'b1);
        chk({dn, tm, n >= 15}, 3'h5);
    endtask
    task automatic t_par(input logic s);
        {ack_dly, par_fault} <= {8'h02, 1'b1};
        tx(2'h0, 32'h0000_0200, 1'b0, s, 1'b0);
        par_fault <= 1'b0;
        rd(8'h04);
        chk(rv[1], s);
        wr(8'h18, 32'h2);
    endtask
    task automatic t_wait;
        {ack_dly, wait_len} <= {8'h02, 8'h06};
        tx(2'h2, 32'h0000_0300, 1'b0, 1'b0, 1'b0);
        chk({dn, n > 6}, 2'h3);
        wait_len <= 8'h00;
    endtask
    task automatic t_tmo(input logic [7:0] monitor_timeout_count, input logic [3:0] ps, input logic dis);
        int p;
        p = (monitor_timeout_count == 8'h00 ? 256 : monitor_timeout_count) * (ps + 1);
        wr(8'h08, {31'h0, dis});
        wr(8'h00, {16'h0, monitor_timeout_count, 4'h0, ps});
        ack_dly <= 8'hff;
        tx(2'h1, 32'h0000_5420, 1'b1, 1'b1, 1'b0);
        chk(tm, 1'b1);
        chk(local_address_bus_out, 32'h0000_5420);
        chk(n >= p - 3 && n <= p + 1, 1'b1);
        rd(8'h04);
        chk(rv[0], !dis);
        rd(8'h10);
        if (!dis) chk(rv, 32'h0000_5420);
        rd(8'h0c);
        if (!dis) chk({rv[15:11], rv[0]}, 6'h27);
        chk(irq_out, 1'b0);
        wr(8'h14, 32'h1);
        cyc(2);
        chk(irq_out, !dis);
        wr(8'h18, 32'h1);
        cyc(2);
        chk(irq_out, 1'b0);
        wr(8'h14, 32'h0);
        wr(8'h08, 32'h0);
    endtask
    task automatic t_address_latch_strobe(input logic hr, rc, por, nm, input logic [31:0] a, input logic e);
        {hard_reset_in, rcw_from_bus_in, power_on_reset_in} <= {hr, rc, por};
        {non_mux_mode_in, ack_dly} <= {nm, 8'h0a};
        cyc(2);
        power_on_reset_in <= 1'b0;
        fork
            tx(2'h1, a, 1'b0, 1'b1, 1'b0);
            begin
                cyc(4);
                chk(address_latch_strobe_out, e);
            end
        join
        hard_reset_in <= 1'b0;
    endtask
    initial begin
        {rst_n_in, power_on_reset_in, hard_reset_in, non_mux_mode_in} = 4'h0;
        {rcw_from_bus_in, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {req_valid_in, req_write_in, req_single_in, req_special_in} = 4'h0;
        {req_machine_in, req_source_in, par_fault, ack_dly, wait_len} = '0;
        {awaddr, wdata, araddr, req_addr_in} = '0;
        wstrb = 4'hf;
        errors = 0;
        compares = 0;
        cyc(2);
        rst_n_in <= 1'b1;
        t_regs;
        t_done;
        t_par(1'b1);
        t_par(1'b0);
        t_wait;
        t_tmo(8'h05, 4'h7, 1'b0);
        t_tmo(8'h00, 4'h0, 1'b0);
        t_tmo(8'h05, 4'h7, 1'b1);
        t_tmo(8'h00, 4'hf, 1'b0);
        t_address_latch_strobe(1'b1, 1'b0, 1'b0, 1'b0, 32'h0000_0400, 1'b0);
        t_address_latch_strobe(1'b0, 1'b1, 1'b1, 1'b0, 32'h0000_0400, 1'b0);
        t_address_latch_strobe(1'b0, 1'b0, 1'b0, 1'b0, 32'h0000_0400, 1'b1);
        t_address_latch_strobe(1'b1, 1'b0, 1'b0, 1'b1, 32'h0000_0400, 1'b1);
        t_address_latch_strobe(1'b0, 1'b0, 1'b0, 1'b1, 32'h0000_0000, 1'b0);
        final_report;
    end
endmodule
